// ===== src/tfh_map.vh
`ifndef TFH_MAP_VH
`define TFH_MAP_VH
// ----------------------------------------
// panel geometry and link timing
// ----------------------------------------
`define TFH_H_ACTIVE 480
`define TFH_V_ACTIVE 854
`define TFH_H_FRONT 8
`define TFH_H_SYNC 4
`define TFH_H_BACK 8
`define TFH_V_FRONT 4
`define TFH_V_SYNC 2
`define TFH_V_BACK 4
// pixel clock half period in system clocks (250 MHz / 8 = 31.25 MHz)
`define TFH_PCLK_HALF 4
// serial clock half period in system clocks
`define TFH_SCLK_HALF 8
// reset timing in ns and derived cycle counts at 4 ns per clock
`define TFH_CLK_NS 4
`define TFH_RST_LOW_NS 10000
`define TFH_RST_WAIT_NS 120000
`define TFH_RST_LOW_CYC ((`TFH_RST_LOW_NS + `TFH_CLK_NS - 1) / `TFH_CLK_NS)
`define TFH_RST_WAIT_CYC ((`TFH_RST_WAIT_NS + `TFH_CLK_NS - 1) / `TFH_CLK_NS)
// colour depth codes
`define TFH_DEPTH_16 2'b00
`define TFH_DEPTH_18 2'b01
`define TFH_DEPTH_24 2'b10
// lane masks that keep the upper bits of each colour
`define TFH_MASK_16 24'hF8_FCF8
`define TFH_MASK_18 24'hFC_FCFC
// serial word lengths
`define TFH_BITS_3W 9
`define TFH_BITS_4W 8
`endif

// ===== src/tfh_fifo.v
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// pixel word fifo
// ----------------------------------------
module tfh_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and control
  input wire clk,
  input wire srst,
  input wire ce,
  // write side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // read side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  reg [AW:0] cnt_next;
  reg rdy_reg;
  wire push;
  wire pop;
  // handshake terms; ready comes from a flop fed by the next count
  assign in_ready = rdy_reg;
  assign out_valid = (cnt_reg != 0);
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;
  // next occupancy
  always @* begin
    cnt_next = cnt_reg;
    if (push && !pop)
      cnt_next = cnt_reg + 1'b1;
    else if (pop && !push)
      cnt_next = cnt_reg - 1'b1;
  end
  // storage and pointers
  always @(posedge clk) begin
    if (srst) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      rdy_reg <= 1'b1;
    end else begin
      if (push) begin
        mem[wr_reg] <= in_data;
        wr_reg <= (wr_reg == DEPTH-1) ? {AW{1'b0}} : wr_reg + 1'b1;
      end
      if (pop)
        rd_reg <= (rd_reg == DEPTH-1) ? {AW{1'b0}} : rd_reg + 1'b1;
      cnt_reg <= cnt_next;
      rdy_reg <= (cnt_next != DEPTH);
    end
  end
endmodule // tfh_fifo
`default_nettype wire

// ===== src/tfh_host.v
// How it works
// - select one means data, zero command
// - three-wire nine bits, four-wire eight bits
// - chip select low across whole transfer
// - hardware reset pulsed before ports are used
// - twenty-four bit bus, unused lanes held low
// - pixel valid marks visible pixel cycles
// - pixel clock runs continuously during output
// - line sync pulse starts every line
// - frame sync pulse starts every frame
// - 480 pixels per line, 854 lines
// - 16, 18, 24 bit colour depths
`timescale 1ns/100ps
`default_nettype none
`include "tfh_map.vh"
module tfh_host #(
  parameter RST_LOW_CYC = `TFH_RST_LOW_CYC,
  parameter RST_WAIT_CYC = `TFH_RST_WAIT_CYC,
  parameter H_ACTIVE = `TFH_H_ACTIVE,
  parameter V_ACTIVE = `TFH_V_ACTIVE,
  parameter FIFO_DEPTH = 16
) (
  // clock, reset, enable
  input wire CLK,
  input wire SRST,
  input wire CE,
  // configuration
  input wire FOUR_WIRE,
  input wire [1:0] DEPTH_SEL,
  // serial command port
  input wire CMD_VALID,
  input wire CMD_DC,
  input wire CMD_RD,
  input wire [7:0] CMD_DATA,
  output reg CMD_READY,
  output reg RD_VALID,
  output reg [7:0] RD_DATA,
  // pixel stream
  input wire PIX_VALID,
  output wire PIX_READY,
  input wire [23:0] PIX_DATA,
  // status
  output reg INIT_DONE,
  output reg UNDERRUN,
  // panel pins
  output reg PANEL_RESET_N,
  output reg SER_CS_N,
  output reg SER_CLK,
  output reg SERIAL_WRITE_IN,
  output reg DATA_COMMAND_SELECT,
  input wire SERIAL_READBACK_OUT,
  output reg [23:0] PIXEL_DATA_BUS,
  output reg PIXEL_VALID,
  output reg PIXEL_CLOCK,
  output reg LINE_SYNC,
  output reg FRAME_SYNC
);
  // ----------------------------------------
  // power-up reset sequence
  // ----------------------------------------
  localparam RS_LOW = 3'b001;
  localparam RS_WAIT = 3'b010;
  localparam RS_DONE = 3'b100;
  reg [2:0] rs_reg;
  reg [31:0] rcnt_reg;
  // hold panel reset low, then wait before use
  always @(posedge CLK) begin
    if (SRST) begin
      rs_reg <= RS_LOW;
      rcnt_reg <= 32'h0000_0000;
      PANEL_RESET_N <= 1'b0;
      INIT_DONE <= 1'b0;
    end else if (CE) begin
      rcnt_reg <= rcnt_reg + 32'h0000_0001;
      case (rs_reg)
        RS_LOW: begin
          PANEL_RESET_N <= 1'b0;
          if (rcnt_reg >= RST_LOW_CYC - 1) begin
            rs_reg <= RS_WAIT;
            rcnt_reg <= 32'h0000_0000;
            PANEL_RESET_N <= 1'b1;
          end
        end
        RS_WAIT: begin
          if (rcnt_reg >= RST_WAIT_CYC - 1) begin
            rs_reg <= RS_DONE;
            INIT_DONE <= 1'b1;
          end
        end
        default: begin
          rs_reg <= RS_DONE;
        end
      endcase
    end
  end
  // ----------------------------------------
  // serial configuration master
  // ----------------------------------------
  reg rb_s1_reg;
  reg rb_s2_reg;
  reg ser_busy_reg;
  reg [8:0] sh_reg;
  reg [3:0] bit_reg;
  reg [3:0] hcnt_reg;
  reg rd_op_reg;
  reg [7:0] rx_reg;
  wire [3:0] nbits;
  assign nbits = FOUR_WIRE ? 4'd`TFH_BITS_4W : 4'd`TFH_BITS_3W;
  // read-back pin synchroniser
  always @(posedge CLK) begin
    if (SRST) begin
      rb_s1_reg <= 1'b0;
      rb_s2_reg <= 1'b0;
    end else if (CE) begin
      rb_s1_reg <= SERIAL_READBACK_OUT;
      rb_s2_reg <= rb_s1_reg;
    end
  end
  // word shifter: data on falling edge, panel samples on rising
  always @(posedge CLK) begin
    if (SRST) begin
      ser_busy_reg <= 1'b0;
      SER_CS_N <= 1'b1;
      SER_CLK <= 1'b0;
      SERIAL_WRITE_IN <= 1'b0;
      DATA_COMMAND_SELECT <= 1'b0;
      CMD_READY <= 1'b0;
      RD_VALID <= 1'b0;
      RD_DATA <= 8'h00;
      sh_reg <= 9'h000;
      bit_reg <= 4'h0;
      hcnt_reg <= 4'h0;
      rd_op_reg <= 1'b0;
      rx_reg <= 8'h00;
    end else if (CE) begin
      RD_VALID <= 1'b0;
      CMD_READY <= INIT_DONE && !ser_busy_reg && !CMD_VALID;
      if (!ser_busy_reg) begin
        if (INIT_DONE && CMD_VALID && !CMD_READY) begin
          ser_busy_reg <= 1'b1;
          SER_CS_N <= 1'b0;
          DATA_COMMAND_SELECT <= CMD_DC;
          rd_op_reg <= CMD_RD;
          // select bit leads in three-wire mode
          sh_reg <= FOUR_WIRE ? {CMD_DATA, 1'b0} : {CMD_DC, CMD_DATA};
          SERIAL_WRITE_IN <= FOUR_WIRE ? CMD_DATA[7] : CMD_DC;
          bit_reg <= 4'h0;
          hcnt_reg <= 4'h0;
          SER_CLK <= 1'b0;
        end
      end else if (hcnt_reg == `TFH_SCLK_HALF - 1) begin
        hcnt_reg <= 4'h0;
        SER_CLK <= !SER_CLK;
        if (!SER_CLK) begin
          // rising edge: panel samples; read-back was set on last fall
          rx_reg <= {rx_reg[6:0], rb_s2_reg};
        end else begin
          // falling edge: next bit or end of word
          if (bit_reg == nbits - 1) begin
            ser_busy_reg <= 1'b0;
            SER_CS_N <= 1'b1;
            RD_VALID <= rd_op_reg;
            RD_DATA <= rx_reg;
          end else begin
            bit_reg <= bit_reg + 4'h1;
            sh_reg <= {sh_reg[7:0], 1'b0};
            SERIAL_WRITE_IN <= sh_reg[7];
          end
        end
      end else begin
        hcnt_reg <= hcnt_reg + 4'h1;
      end
    end
  end
  // ----------------------------------------
  // pixel fifo
  // ----------------------------------------
  wire fifo_valid;
  wire [23:0] fifo_data;
  reg fifo_pop;
  tfh_fifo #(
    .WIDTH(24),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .clk(CLK),
    .srst(SRST),
    .ce(CE),
    .in_valid(PIX_VALID),
    .in_ready(PIX_READY),
    .in_data(PIX_DATA),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );
  // ----------------------------------------
  // rgb timing generator
  // ----------------------------------------
  localparam H_TOTAL = H_ACTIVE + `TFH_H_FRONT + `TFH_H_SYNC + `TFH_H_BACK;
  localparam V_TOTAL = V_ACTIVE + `TFH_V_FRONT + `TFH_V_SYNC + `TFH_V_BACK;
  reg [2:0] pdiv_reg;
  reg [10:0] hc_reg;
  reg [10:0] vc_reg;
  wire fall_tick;
  wire active;
  wire [23:0] masked;
  assign fall_tick = (pdiv_reg == `TFH_PCLK_HALF - 1) && PIXEL_CLOCK;
  assign active = (hc_reg < H_ACTIVE) && (vc_reg < V_ACTIVE);
  // drop unused low lanes per colour depth
  assign masked = (DEPTH_SEL == `TFH_DEPTH_16) ? (fifo_data & `TFH_MASK_16) :
                  (DEPTH_SEL == `TFH_DEPTH_18) ? (fifo_data & `TFH_MASK_18) :
                  fifo_data;
  // pop one word per active pixel clock
  always @* begin
    fifo_pop = fall_tick && active && INIT_DONE;
  end
  // pixel clock divider and counters; outputs change on falling edge
  always @(posedge CLK) begin
    if (SRST) begin
      pdiv_reg <= 3'h0;
      PIXEL_CLOCK <= 1'b0;
      hc_reg <= 11'h000;
      vc_reg <= 11'h000;
      PIXEL_DATA_BUS <= 24'h00_0000;
      PIXEL_VALID <= 1'b0;
      LINE_SYNC <= 1'b0;
      FRAME_SYNC <= 1'b0;
      UNDERRUN <= 1'b0;
    end else if (CE && INIT_DONE) begin
      if (pdiv_reg == `TFH_PCLK_HALF - 1) begin
        pdiv_reg <= 3'h0;
        PIXEL_CLOCK <= !PIXEL_CLOCK;
      end else begin
        pdiv_reg <= pdiv_reg + 3'h1;
      end
      if (fall_tick) begin
        PIXEL_VALID <= active;
        PIXEL_DATA_BUS <= (active && fifo_valid) ? masked : 24'h00_0000;
        UNDERRUN <= UNDERRUN | (active && !fifo_valid);
        LINE_SYNC <= (hc_reg >= H_ACTIVE + `TFH_H_FRONT) &&
                     (hc_reg < H_ACTIVE + `TFH_H_FRONT + `TFH_H_SYNC);
        FRAME_SYNC <= (vc_reg >= V_ACTIVE + `TFH_V_FRONT) &&
                      (vc_reg < V_ACTIVE + `TFH_V_FRONT + `TFH_V_SYNC);
        if (hc_reg == H_TOTAL - 1) begin
          hc_reg <= 11'h000;
          vc_reg <= (vc_reg == V_TOTAL - 1) ? 11'h000 : vc_reg + 11'h001;
        end else begin
          hc_reg <= hc_reg + 11'h001;
        end
      end
    end
  end
endmodule // tfh_host
`default_nettype wire

// ===== testbench/tfh_host_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// pin timing checker
// ----------------------------------------
module tfh_host_chk #(
  parameter H_ACTIVE = 480,
  parameter V_ACTIVE = 854
) (
  // clock and status
  input wire CLK,
  input wire SRST,
  input wire INIT_DONE,
  input wire RD_VALID,
  input wire [1:0] DEPTH_SEL,
  // panel pins
  input wire PANEL_RESET_N,
  input wire SER_CS_N,
  input wire SER_CLK,
  input wire SERIAL_WRITE_IN,
  input wire DATA_COMMAND_SELECT,
  input wire [23:0] PIXEL_DATA_BUS,
  input wire PIXEL_VALID,
  input wire PIXEL_CLOCK,
  input wire LINE_SYNC,
  input wire FRAME_SYNC
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic pc_q, pv_q, ls_q, fs_q;
  int px_cnt;
  int ln_cnt;
  // visible pixels per line, visible lines per frame
  always @(posedge CLK) begin
    pc_q <= PIXEL_CLOCK;
    pv_q <= PIXEL_VALID;
    ls_q <= LINE_SYNC;
    fs_q <= FRAME_SYNC;
    if (SRST || (LINE_SYNC && !ls_q)) px_cnt <= 0;
    else if (PIXEL_CLOCK && !pc_q && PIXEL_VALID) px_cnt <= px_cnt + 1;
    if (SRST || (FRAME_SYNC && !fs_q)) ln_cnt <= 0;
    else if (PIXEL_VALID && !pv_q) ln_cnt <= ln_cnt + 1;
  end
  chk_clk_in_cs: assert property (SER_CLK |-> !SER_CS_N)
    else $error("serial clock outside select");
  chk_sdi_setup: assert property ($rose(SER_CLK) |-> $stable(SERIAL_WRITE_IN)
    && $stable(DATA_COMMAND_SELECT)) else $error("serial data moved at rise");
  chk_sclk_half: assert property ($rose(SER_CLK) |=> SER_CLK [*7] ##1 !SER_CLK)
    else $error("serial clock half period");
  chk_idle_quiet: assert property (!INIT_DONE |-> SER_CS_N && !PIXEL_VALID)
    else $error("port used before init");
  chk_reset_pulse: assert property ($fell(SRST) |-> !PANEL_RESET_N [*4])
    else $error("panel reset too short");
  chk_pclk_run: assert property ($rose(PIXEL_CLOCK) |=> PIXEL_CLOCK [*3] ##1
    !PIXEL_CLOCK [*4] ##1 PIXEL_CLOCK) else $error("pixel clock period");
  chk_pix_on_fall: assert property ($changed(PIXEL_DATA_BUS) || $changed(PIXEL_VALID)
    |-> $fell(PIXEL_CLOCK)) else $error("pixel change off clock fall");
  chk_sync_blank: assert property (PIXEL_VALID |-> !LINE_SYNC && !FRAME_SYNC)
    else $error("sync during visible pixel");
  chk_lane_mask: assert property (DEPTH_SEL == 2'b00
    |-> (PIXEL_DATA_BUS & 24'h07_0307) == 24'h00_0000) else $error("lanes not masked");
  chk_line_len: assert property ($rose(LINE_SYNC) |-> px_cnt == 0 || px_cnt == H_ACTIVE)
    else $error("pixels per line");
  chk_frame_len: assert property ($rose(FRAME_SYNC) |-> ln_cnt == 0 || ln_cnt == V_ACTIVE)
    else $error("lines per frame");
  chk_rd_end: assert property (RD_VALID |-> SER_CS_N)
    else $error("read result inside word");
  cover property ($rose(RD_VALID));
  cover property ($rose(LINE_SYNC) && px_cnt == H_ACTIVE);
  cover property ($rose(FRAME_SYNC) && ln_cnt == V_ACTIVE);
endmodule // tfh_host_chk
bind tfh_host tfh_host_chk #(.H_ACTIVE(H_ACTIVE), .V_ACTIVE(V_ACTIVE)) u_chk (
  .CLK(CLK), .SRST(SRST), .INIT_DONE(INIT_DONE), .RD_VALID(RD_VALID), .DEPTH_SEL(DEPTH_SEL),
  .PANEL_RESET_N(PANEL_RESET_N), .SER_CS_N(SER_CS_N), .SER_CLK(SER_CLK),
  .SERIAL_WRITE_IN(SERIAL_WRITE_IN), .DATA_COMMAND_SELECT(DATA_COMMAND_SELECT),
  .PIXEL_DATA_BUS(PIXEL_DATA_BUS), .PIXEL_VALID(PIXEL_VALID), .PIXEL_CLOCK(PIXEL_CLOCK),
  .LINE_SYNC(LINE_SYNC), .FRAME_SYNC(FRAME_SYNC));
`default_nettype wire

// ===== testbench/tfh_panel.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// panel model: serial slave and pixel sink
// ----------------------------------------
module tfh_panel (
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_write_in,
  input wire logic dcx,
  input wire logic four_wire,
  input wire logic [7:0] rb_byte,
  output logic serial_readback_out,
  // pixel pins
  input wire logic pclk,
  input wire logic pvalid,
  input wire logic [23:0] pbus
);
  logic [8:0] sh = 9'h000;
  int idx = -1;
  logic [8:0] words[$];
  logic [23:0] pix[$];
  initial serial_readback_out = 1'b0;
  // word start: four-wire shows the first read bit at once
  always @(negedge cs_n) begin
    sh = 9'h000;
    idx = four_wire ? 6 : 7;
    serial_readback_out <= four_wire ? rb_byte[7] : ~serial_readback_out;
  end
  // read-back changes at each clock fall, toggles when unused
  always @(negedge sclk) begin
    if (!cs_n && idx >= 0) serial_readback_out <= rb_byte[idx];
    else serial_readback_out <= ~serial_readback_out;
    idx = idx - 1;
  end
  // write bits taken at rise, only under select
  always @(posedge sclk) begin
    if (!cs_n) sh = {sh[7:0], serial_write_in};
    if (!cs_n && four_wire) sh[8] = dcx;
  end
  // word end: store select flag and byte, toggle read line
  always @(posedge cs_n) begin
    words.push_back(sh);
    serial_readback_out <= ~serial_readback_out;
  end
  // visible pixels captured at pixel clock rise
  always @(posedge pclk) begin
    if (pvalid === 1'b1) pix.push_back(pbus);
  end
endmodule // tfh_panel
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module tb_top;
  logic clk, srst, four_wire, cmd_valid, cmd_dc, cmd_rd, pix_valid;
  logic [1:0] depth_sel;
  logic [7:0] cmd_data, rb_byte;
  logic [23:0] pix_data;
  wire cmd_ready, rd_valid, pix_ready, init_done, underrun, panel_reset_n, ser_cs_n, ser_clk;
  wire serial_write_in, dcx, serial_readback_out, pixel_valid, pixel_clock, line_sync, frame_sync;
  wire [7:0] rd_data;
  wire [23:0] pixel_data_bus;
  int errors, n_checks, cyc;
  logic [23:0] expq[$];
  tfh_host #(.RST_LOW_CYC(4), .RST_WAIT_CYC(8), .H_ACTIVE(8), .V_ACTIVE(4)) DUT (
    .CLK(clk), .SRST(srst), .CE(1'b1), .FOUR_WIRE(four_wire), .DEPTH_SEL(depth_sel),
    .CMD_VALID(cmd_valid), .CMD_DC(cmd_dc), .CMD_RD(cmd_rd), .CMD_DATA(cmd_data),
    .CMD_READY(cmd_ready), .RD_VALID(rd_valid), .RD_DATA(rd_data), .PIX_VALID(pix_valid),
    .PIX_READY(pix_ready), .PIX_DATA(pix_data), .INIT_DONE(init_done), .UNDERRUN(underrun),
    .PANEL_RESET_N(panel_reset_n), .SER_CS_N(ser_cs_n), .SER_CLK(ser_clk),
    .SERIAL_WRITE_IN(serial_write_in), .DATA_COMMAND_SELECT(dcx), .SERIAL_READBACK_OUT(serial_readback_out),
    .PIXEL_DATA_BUS(pixel_data_bus), .PIXEL_VALID(pixel_valid), .PIXEL_CLOCK(pixel_clock),
    .LINE_SYNC(line_sync), .FRAME_SYNC(frame_sync));
  tfh_panel panel (.cs_n(ser_cs_n), .sclk(ser_clk), .serial_write_in(serial_write_in), .dcx(dcx),
    .four_wire(four_wire), .rb_byte(rb_byte), .serial_readback_out(serial_readback_out), .pclk(pixel_clock),
    .pvalid(pixel_valid), .pbus(pixel_data_bus));
  // 250 MHz clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic do_reset();
    int i;
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    check("cs in reset", 24'h00_0001, {23'h0, ser_cs_n});
    srst <= 1'b0;
    i = 0;
    while (init_done !== 1'b1 && i < 100) begin
      @(posedge clk);
      i++;
    end
    check("panel reset", 24'h00_0001, {23'h0, panel_reset_n});
    panel.words.delete();
    panel.pix.delete();
  endtask
  // one serial word, optional read-back; request dropped once taken
  task automatic ser_word(input logic fw, input logic dc, input logic rd, input logic [7:0] d);
    int i, seen;
    four_wire <= fw;
    cmd_dc <= dc;
    cmd_rd <= rd;
    cmd_data <= d;
    rb_byte <= 8'($urandom);
    cmd_valid <= 1'b1;
    i = 0;
    while (ser_cs_n !== 1'b0 && i < 50) begin
      @(posedge clk);
      i++;
    end
    // a request still held after the word ends would be sent again
    cmd_valid <= 1'b0;
    i = 0;
    seen = 0;
    while (cmd_ready !== 1'b1 && i < 400) begin
      @(posedge clk);
      i++;
      if (rd_valid === 1'b1) begin
        seen++;
        check("read byte", {16'h0, rb_byte}, {16'h0, rd_data});
      end
    end
    check("read pulses", 24'(rd), 24'(seen));
    check("word", {15'h0, dc, d}, {15'h0, panel.words.pop_front()});
  endtask
  // push 32 words, fifo must refuse at least once, then compare visible pixels with masked stream
  task automatic pix_run(input logic [1:0] ds, input logic [23:0] m);
    int i, n, full;
    logic [23:0] g;
    depth_sel <= ds;
    do_reset();
    n = 0;
    full = 0;
    pix_data <= 24'h80_0000 | 24'($urandom);
    pix_valid <= 1'b1;
    while (n < 32) begin
      @(posedge clk);
      if (pix_ready === 1'b1) begin
        expq.push_back(pix_data & m);
        n++;
        pix_data <= 24'h80_0000 | 24'($urandom);
      end else full = 1;
    end
    pix_valid <= 1'b0;
    check("fifo refused", 24'h00_0001, 24'(full));
    i = 0;
    while (expq.size() > 0 && i < 20000) begin
      @(posedge clk);
      i++;
      while (panel.pix.size() > 0 && expq.size() > 0) begin
        g = panel.pix.pop_front();
        check("pixel", expq.pop_front(), g);
      end
    end
    check("pixels left", 24'h00_0000, 24'(expq.size()));
    repeat (3200) @(posedge clk);
    check("underrun", 24'h00_0001, {23'h0, underrun});
    $display("test pixel depth %0d done", ds);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {srst, four_wire, cmd_valid, cmd_dc, cmd_rd, pix_valid} = 6'b100010;
    {cmd_data, rb_byte, pix_data, depth_sel} = 42'h0;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(56458));
    do_reset();
    for (int k = 0; k < 4; k++) ser_word(k[1], k[0], k[1] ^ k[0], 8'($urandom));
    $display("test serial done");
    pix_run(2'b00, 24'hf8_fcf8);
    pix_run(2'b01, 24'hfc_fcfc);
    pix_run(2'b10, 24'hff_ffff);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
